// [src/sssg_pkg.sv]
// Constants, types and register map of the supply status and start-up gate.
//Contract
//- Strobe low drives six flags; high floats them
//- Overvoltage flag high when strobed and sense low
//- Overvoltage flag floats while strobe high
//- Overtemperature flag high when strobed, sense low
//- Overtemperature flag floats while strobe high
//- Positive-limit output shows latch, low means limit
//- Constant-voltage output shows latch, low means mode
//- Negative-limit loop low drives its output low
//- Positive-limit loop high makes output read low
//- Regulation loop medium is CV, high unregulated
//- Several flags together during transients are legal
//- Bias good advances delay; loss resets it fast
//- Power-clear-ready rises and holds at delay end
//- Output-on only when ready and enable low
//- Bias good is unregulated bias and rail ok
//- Five status inputs decode onto six outputs
package sssg_pkg;
	localparam int CLK_NS = 5;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int STARTUP_DELAY_US = 100;
	localparam int ADDR_W = 5;
	localparam int CNT_W = 16;
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h04;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h08;
	localparam logic [4:0] OFS_DELAY = 5'h0c;
	localparam logic [4:0] OFS_TIMER = 5'h10;
	localparam int STS_PCR = 6;
	localparam int STS_ON = 7;
	localparam int STS_BIAS = 8;
	localparam int IRQ_W = 4;
	localparam logic [3:0] RST_IRQ_MASK = 4'h0;
	localparam int PIN_OEN = 0;
	localparam int PIN_RAIL = 1;
	localparam int PIN_UBIAS = 2;
	localparam int PIN_REG = 3;
	localparam int PIN_POS = 5;
	localparam int PIN_NEG = 6;
	localparam int PIN_TEMP = 7;
	localparam int PIN_OV = 8;
	localparam int PIN_STB = 9;
	localparam int PIN_W = 10;
	localparam logic [9:0] SYNC_RST = 10'h3c1;
	localparam logic [1:0] LVL_MED = 2'h1;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHARGE = 2'b01,
		ST_READY = 2'b11
	} sssg_state_e;
	typedef struct packed {
		logic excessHeatFlag;
		logic excessVoltFlag;
		logic unregStatus;
		logic negLimitStatus;
		logic posLimitStatus;
		logic constVoltStatus;
	} sssg_flags_s;
	typedef struct packed {
		logic unreg;
		logic negLim;
		logic posLim;
		logic constVolt;
	} sssg_modes_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} sssg_req_s;
endpackage : sssg_pkg

// [src/sssg_top.sv]
// Status decoder, status bus gate and power-on sequencer.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module sssg_top #(
	parameter int DELAY_US = sssg_pkg::STARTUP_DELAY_US, // Delay in us.
	parameter int TICK_CYC = sssg_pkg::TICK_CYC // Cycles per us.
) (
	input wire logic clk_sys, // System clock.
	input wire logic rst, // Synchronous reset.
	input wire logic excessVoltSenseIn, // Low on overvoltage.
	input wire logic tempSenseIn, // Low on overtemperature.
	input wire logic negLimitLoopIn, // Low in negative limit.
	input wire logic posLimitLoopIn, // High in positive limit.
	input wire logic [1:0] regulationLoopIn, // Level code.
	input wire logic unregBiasOkIn, // Unregulated bias ok.
	input wire logic mediumRailOkIn, // Medium rail ok.
	input wire logic statusStrobeN, // Status read strobe.
	input wire logic outputEnableN, // Output enable.
	output sssg_pkg::sssg_flags_s statusBusOut, // Status bus data.
	output sssg_pkg::sssg_flags_s statusBusOeN, // Low drives pin.
	output logic biasGood, // Bias supplies good.
	output logic powerClearReady, // Start-up delay done.
	output logic outputOn, // Output stage enabled.
	input sssg_pkg::sssg_req_s regReq, // Register request.
	output logic [31:0] regRdata, // Read data.
	output logic irq // Level interrupt.
);
	localparam logic [sssg_pkg::CNT_W-1:0] DELAY_RST =
		sssg_pkg::CNT_W'(DELAY_US);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

	logic [sssg_pkg::PIN_W-1:0] sync1_r;
	logic [sssg_pkg::PIN_W-1:0] sync2_r;
	sssg_pkg::sssg_modes_s modeLatch_r;
	sssg_pkg::sssg_flags_s busOut_r;
	sssg_pkg::sssg_flags_s busOeN_r;
	sssg_pkg::sssg_state_e state_r;
	sssg_pkg::sssg_state_e stateNxt;
	logic [15:0] tickCnt_r;
	logic [sssg_pkg::CNT_W-1:0] usCnt_r;
	logic [sssg_pkg::CNT_W-1:0] usCntNxt;
	logic [sssg_pkg::CNT_W-1:0] delayLimit_r;
	logic biasGood_r;
	logic pcr_r;
	logic outputOn_r;
	logic ovPrev_r;
	logic otPrev_r;
	logic [sssg_pkg::IRQ_W-1:0] irqStat_r;
	logic [sssg_pkg::IRQ_W-1:0] irqMask_r;
	logic irq_r;
	logic [31:0] rdata_r;

	wire [sssg_pkg::PIN_W-1:0] pinRaw = {statusStrobeN, excessVoltSenseIn,
		tempSenseIn, negLimitLoopIn, posLimitLoopIn, regulationLoopIn,
		unregBiasOkIn, mediumRailOkIn, outputEnableN};

	// Pin inputs are resynchronised before any decoding.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1_r <= sssg_pkg::SYNC_RST;
			sync2_r <= sssg_pkg::SYNC_RST;
		end else begin
			sync1_r <= pinRaw;
			sync2_r <= sync1_r;
		end
	end

	// Each condition is decoded on its own, so several may show at once.
	wire strobeLow = ~sync2_r[sssg_pkg::PIN_STB];
	wire ovNow = ~sync2_r[sssg_pkg::PIN_OV];
	wire otNow = ~sync2_r[sssg_pkg::PIN_TEMP];
	wire [1:0] regLevel = sync2_r[sssg_pkg::PIN_REG +: 2];
	wire enableLow = ~sync2_r[sssg_pkg::PIN_OEN];
	wire biasNow = sync2_r[sssg_pkg::PIN_UBIAS]
		& sync2_r[sssg_pkg::PIN_RAIL];
	sssg_pkg::sssg_modes_s modeNow;
	assign modeNow.negLim = ~sync2_r[sssg_pkg::PIN_NEG];
	assign modeNow.posLim = sync2_r[sssg_pkg::PIN_POS];
	assign modeNow.constVolt = (regLevel == sssg_pkg::LVL_MED);
	assign modeNow.unreg = regLevel[1];

	// Mode latches track the loops and freeze while a read is under way.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			modeLatch_r <= '0;
		end else if (!strobeLow) begin
			modeLatch_r <= modeNow;
		end
	end

	sssg_pkg::sssg_flags_s flagsNow;
	assign flagsNow.excessHeatFlag = otNow;
	assign flagsNow.excessVoltFlag = ovNow;
	assign flagsNow.unregStatus = ~modeLatch_r.unreg;
	assign flagsNow.negLimitStatus = ~modeLatch_r.negLim;
	assign flagsNow.posLimitStatus = ~modeLatch_r.posLim;
	assign flagsNow.constVoltStatus = ~modeLatch_r.constVolt;
	wire sssg_pkg::sssg_flags_s busOutNxt = strobeLow ? flagsNow : '0;
	wire sssg_pkg::sssg_flags_s busOeNNxt = strobeLow ? '0 : '1;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busOut_r <= '0;
			busOeN_r <= '1;
		end else begin
			busOut_r <= busOutNxt;
			busOeN_r <= busOeNNxt;
		end
	end

	// Microsecond tick runs only while the delay is charging.
	wire charging = (state_r == sssg_pkg::ST_CHARGE);
	wire tick = charging && (tickCnt_r == TICK_LAST);
	wire atLimit = (usCnt_r >= delayLimit_r);

	always_comb begin
		stateNxt = state_r;
		usCntNxt = usCnt_r;
		case (state_r)
			sssg_pkg::ST_IDLE: begin
				stateNxt = sssg_pkg::ST_CHARGE;
			end
			sssg_pkg::ST_CHARGE: begin
				if (atLimit) begin
					stateNxt = sssg_pkg::ST_READY;
				end else if (tick) begin
					usCntNxt = usCnt_r + 1'b1;
				end
			end
			sssg_pkg::ST_READY: begin
				stateNxt = sssg_pkg::ST_READY;
			end
			default: begin
				stateNxt = sssg_pkg::ST_IDLE;
			end
		endcase
		if (!biasNow) begin
			stateNxt = sssg_pkg::ST_IDLE;
			usCntNxt = '0;
		end
	end

	wire pcrNxt = (stateNxt == sssg_pkg::ST_READY);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= sssg_pkg::ST_IDLE;
			usCnt_r <= '0;
			tickCnt_r <= '0;
			biasGood_r <= 1'b0;
			pcr_r <= 1'b0;
			outputOn_r <= 1'b0;
		end else begin
			state_r <= stateNxt;
			usCnt_r <= usCntNxt;
			tickCnt_r <= (!charging || tick) ? '0 : tickCnt_r + 1'b1;
			biasGood_r <= biasNow;
			pcr_r <= pcrNxt;
			outputOn_r <= pcrNxt && enableLow;
		end
	end

	// Register port and interrupt logic.
	wire wrStat = regReq.wr && (regReq.addr == sssg_pkg::OFS_IRQ_STAT);
	wire wrMask = regReq.wr && (regReq.addr == sssg_pkg::OFS_IRQ_MASK);
	wire wrDelay = regReq.wr && (regReq.addr == sssg_pkg::OFS_DELAY);
	wire [3:0] evt = {pcr_r & ~pcrNxt, ~pcr_r & pcrNxt,
		otNow & ~otPrev_r, ovNow & ~ovPrev_r};
	wire [3:0] clr = wrStat ? regReq.wdata[3:0] : 4'h0;
	// A new event wins over a clear in the same cycle.
	wire [3:0] irqStatNxt = (irqStat_r & ~clr) | evt;
	wire [3:0] irqMaskNxt = wrMask ? regReq.wdata[3:0] : irqMask_r;
	wire [31:0] statusWord = {23'h0, biasGood_r, outputOn_r, pcr_r,
		otNow, ovNow, modeLatch_r};
	logic [31:0] rdMux;
	always_comb begin
		case (regReq.addr)
			sssg_pkg::OFS_STATUS: rdMux = statusWord;
			sssg_pkg::OFS_IRQ_STAT: rdMux = {28'h0, irqStat_r};
			sssg_pkg::OFS_IRQ_MASK: rdMux = {28'h0, irqMask_r};
			sssg_pkg::OFS_DELAY: rdMux = {16'h0, delayLimit_r};
			sssg_pkg::OFS_TIMER: rdMux = {16'h0, usCnt_r};
			default: rdMux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqStat_r <= '0;
			irqMask_r <= sssg_pkg::RST_IRQ_MASK;
			delayLimit_r <= DELAY_RST;
			ovPrev_r <= 1'b0;
			otPrev_r <= 1'b0;
			irq_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			irqStat_r <= irqStatNxt;
			irqMask_r <= irqMaskNxt;
			if (wrDelay) begin
				delayLimit_r <= regReq.wdata[15:0];
			end
			ovPrev_r <= ovNow;
			otPrev_r <= otNow;
			irq_r <= |(irqStatNxt & irqMaskNxt);
			rdata_r <= regReq.rd ? rdMux : 32'h0;
		end
	end

	assign statusBusOut = busOut_r;
	assign statusBusOeN = busOeN_r;
	assign biasGood = biasGood_r;
	assign powerClearReady = pcr_r;
	assign outputOn = outputOn_r;
	assign regRdata = rdata_r;
	assign irq = irq_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_readWindow;
		strobeLow [*2];
	endsequence

	sequence s_chargeTick;
		charging && tick && !atLimit && biasNow;
	endsequence

	property p_float;
		!strobeLow |=> statusBusOeN == '1 && statusBusOut == '0;
	endproperty
	a_float: assert property (p_float)
		else $error("Status bus not floating while strobe high.");

	property p_drive;
		strobeLow |=> statusBusOeN == '0;
	endproperty
	a_drive: assert property (p_drive)
		else $error("Status bus not driven while strobe low.");

	property p_ov;
		strobeLow |=> statusBusOut.excessVoltFlag == $past(ovNow);
	endproperty
	a_ov: assert property (p_ov)
		else $error("Overvoltage flag does not follow sense.");

	property p_ot;
		strobeLow |=> statusBusOut.excessHeatFlag == $past(otNow);
	endproperty
	a_ot: assert property (p_ot)
		else $error("Overtemperature flag does not follow sense.");

	property p_hold;
		s_readWindow |-> $stable(modeLatch_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("Mode latches changed during a read.");

	property p_modes;
		strobeLow |=> {statusBusOut.posLimitStatus,
			statusBusOut.constVoltStatus,
			statusBusOut.negLimitStatus} == ~$past({modeLatch_r.posLim,
			modeLatch_r.constVolt, modeLatch_r.negLim});
	endproperty
	a_modes: assert property (p_modes)
		else $error("Mode status outputs wrong.");

	property p_discharge;
		!biasNow |=> state_r == sssg_pkg::ST_IDLE && usCnt_r == '0
			&& !powerClearReady;
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("Delay not reset on bias loss.");

	property p_charge;
		s_chargeTick |=> usCnt_r == $past(usCnt_r) + 1'b1;
	endproperty
	a_charge: assert property (p_charge)
		else $error("Delay did not advance on tick.");

	property p_ready;
		(charging && atLimit && biasNow) |=> powerClearReady
			&& state_r == sssg_pkg::ST_READY;
	endproperty
	a_ready: assert property (p_ready)
		else $error("Ready not raised at delay end.");

	property p_on;
		outputOn |-> powerClearReady
			&& !$past(sync2_r[sssg_pkg::PIN_OEN]);
	endproperty
	a_on: assert property (p_on)
		else $error("Output on without ready and enable.");

	property p_bias;
		biasGood == $past(biasNow);
	endproperty
	a_bias: assert property (p_bias)
		else $error("Bias good not the conjunction.");

	property p_sync;
		##2 sync2_r == $past(pinRaw, 2);
	endproperty
	a_sync: assert property (p_sync)
		else $error("Input synchroniser depth wrong.");

	property p_unreg;
		strobeLow |=> statusBusOut.unregStatus == !$past(modeLatch_r.unreg);
	endproperty
	a_unreg: assert property (p_unreg)
		else $error("Out of regulation status output wrong.");

	property p_offNoReady;
		!powerClearReady |-> !outputOn;
	endproperty
	a_offNoReady: assert property (p_offNoReady)
		else $error("Output on while not ready.");

	property p_readyHold;
		powerClearReady && biasNow |=> powerClearReady;
	endproperty
	a_readyHold: assert property (p_readyHold)
		else $error("Ready dropped while bias held.");

	property p_readyRise;
		$rose(powerClearReady) |-> $past(charging && atLimit);
	endproperty
	a_readyRise: assert property (p_readyRise)
		else $error("Ready rose before the delay ended.");

	property p_irqLevel;
		irq == |(irqStat_r & irqMask_r);
	endproperty
	a_irqLevel: assert property (p_irqLevel)
		else $error("Interrupt output does not match status and mask.");

	property p_setWins;
		(|evt) |=> ($past(evt) & ~irqStat_r) == 4'h0;
	endproperty
	a_setWins: assert property (p_setWins)
		else $error("Interrupt event not recorded in status.");

	property p_rdIdle;
		!regReq.rd |=> regRdata == 32'h0000_0000;
	endproperty
	a_rdIdle: assert property (p_rdIdle)
		else $error("Read data not idle after a cycle without read.");
endmodule : sssg_top

// [verification/sssg_ctrl_model.sv]
// Controller model that strobes the status bus and drives output enable.
`timescale 1ns/1ps
module sssg_ctrl_model #(
	parameter int STB_CYC = 6000 // Strobe length in cycles.
) (
	input wire logic clk_sys, // Clock.
	input wire logic rst, // Reset.
	input wire logic readReq, // Starts a status read.
	input wire logic selfTestOk, // Own self test passed.
	input wire logic powerClearReady, // Device start-up done.
	input sssg_pkg::sssg_flags_s busOut, // Pin data.
	input sssg_pkg::sssg_flags_s busOeN, // Pin enables.
	output logic statusStrobeN, // Status strobe.
	output logic outputEnableN, // Output enable.
	output sssg_pkg::sssg_flags_s sampled, // Last sample.
	output logic sampleDone // Sample taken.
);
	logic [15:0] cnt;
	sssg_pkg::sssg_flags_s pins;
	// Open-collector lines have pull-ups, so a floating pin reads high.
	assign pins = busOut | busOeN;
	always_ff @(posedge clk_sys) begin
		sampleDone <= 1'b0;
		if (rst) begin
			statusStrobeN <= 1'b1;
			outputEnableN <= 1'b1;
			cnt <= 16'h0000;
		end else begin
			outputEnableN <= ~(powerClearReady & selfTestOk);
			if (statusStrobeN && readReq) begin
				statusStrobeN <= 1'b0;
				cnt <= 16'(STB_CYC - 1);
			end else if (!statusStrobeN) begin
				cnt <= cnt - 16'h0001;
				if (cnt == 16'h0000) begin
					statusStrobeN <= 1'b1;
					sampled <= pins;
					sampleDone <= 1'b1;
				end
			end
		end
	end
endmodule : sssg_ctrl_model

// [verification/tb.sv]
// Self-checking bench of the status decoder and start-up gate.
`timescale 1ns/1ps
module tb;
	localparam int DUS = 2;
	localparam int TCYC = 4;
	localparam logic [11:0] ROWS [9] = '{12'he0f, 12'h61f, 12'ha2f, 12'hc0b,
		12'hf0d, 12'he4e, 12'he87, 12'hec7, 12'h178};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ovSense = 1'b1, tempSense = 1'b1, negLoop = 1'b1, posLoop = 1'b0;
	logic [1:0] regLoop = 2'h0;
	logic ubOk = 1'b0, railOk = 1'b0, readReq = 1'b0, stOk = 1'b0;
	logic strobeN, enableN, biasGood, ready, outputOn, irq, sDone;
	sssg_pkg::sssg_flags_s busOut, busOeN, sampled;
	sssg_pkg::sssg_req_s regReq = '0;
	logic [31:0] regRdata;
	logic [3:0] sigs;
	int failures = 0, checks_done = 0, n;
	assign sigs = {outputOn, ready, biasGood, sDone};
	always #2.5 clk_sys = ~clk_sys;
	sssg_top #(.DELAY_US(DUS), .TICK_CYC(TCYC)) i_sssg_top (.clk_sys(clk_sys),
		.rst(rst), .excessVoltSenseIn(ovSense), .tempSenseIn(tempSense),
		.negLimitLoopIn(negLoop), .posLimitLoopIn(posLoop),
		.regulationLoopIn(regLoop), .unregBiasOkIn(ubOk),
		.mediumRailOkIn(railOk), .statusStrobeN(strobeN),
		.outputEnableN(enableN), .statusBusOut(busOut), .statusBusOeN(busOeN),
		.biasGood(biasGood), .powerClearReady(ready), .outputOn(outputOn),
		.regReq(regReq), .regRdata(regRdata), .irq(irq));
	sssg_ctrl_model #(.STB_CYC(8)) i_sssg_ctrl_model (.clk_sys(clk_sys),
		.rst(rst), .readReq(readReq), .selfTestOk(stOk),
		.powerClearReady(ready), .busOut(busOut), .busOeN(busOeN),
		.statusStrobeN(strobeN), .outputEnableN(enableN), .sampled(sampled),
		.sampleDone(sDone));
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits a bounded time for one of the watched outputs to reach a level.
	task automatic waitSig(input int which, input logic lvl, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge clk_sys);
			#1;
			if (sigs[which] === lvl) begin
				return;
			end
		end
		check(sigs[which], lvl);
		test_done();
	endtask : waitSig
	task automatic regWrite(input logic [4:0] a, input logic [31:0] d);
		regReq <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		regReq <= '0;
		@(posedge clk_sys);
	endtask : regWrite
	task automatic regRead(input logic [4:0] a, input logic [31:0] exp);
		regReq <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk_sys);
		regReq <= '0;
		#1;
		check(regRdata, exp);
		@(posedge clk_sys);
	endtask : regRead
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		check({busOeN, busOut, outputOn, ready}, {6'h3f, 6'h00, 2'b00});
		@(posedge clk_sys);
		regRead(5'h08, 32'h0000_0000);
		regRead(5'h0c, 32'(DUS));
		regRead(5'h1c, 32'h0000_0000);
		foreach (ROWS[i]) begin
			{ovSense, tempSense, negLoop, posLoop, regLoop} <= ROWS[i][11:6];
			repeat (6) @(posedge clk_sys);
			readReq <= 1'b1;
			@(posedge clk_sys);
			readReq <= 1'b0;
			waitSig(0, 1'b1, 20);
			check(sampled, ROWS[i][5:0]);
			repeat (3) @(posedge clk_sys);
			#1;
			check({busOeN, busOut}, {6'h3f, 6'h00});
			@(posedge clk_sys);
			regRead(5'h00, {26'h0, ROWS[i][5:4], ~ROWS[i][3:0]});
		end
		regRead(5'h04, 32'h0000_0003);
		#1;
		check(irq, 1'b0);
		@(posedge clk_sys);
		regWrite(5'h08, 32'h0000_000f);
		#1;
		check(irq, 1'b1);
		@(posedge clk_sys);
		regWrite(5'h04, 32'h0000_0001);
		regRead(5'h04, 32'h0000_0002);
		regWrite(5'h04, 32'h0000_0002);
		#1;
		check(irq, 1'b0);
		@(posedge clk_sys);
		regWrite(5'h08, 32'h0000_0000);
		regWrite(5'h0c, 32'h0000_0003);
		regRead(5'h0c, 32'h0000_0003);
		ubOk <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		check(biasGood, 1'b0);
		@(posedge clk_sys);
		railOk <= 1'b1;
		waitSig(1, 1'b1, 6);
		waitSig(2, 1'b1, 40);
		check(n >= 3 * TCYC && n <= 3 * TCYC + 6, 1'b1);
		repeat (10) @(posedge clk_sys);
		#1;
		check({ready, outputOn}, 2'b10);
		@(posedge clk_sys);
		regRead(5'h10, 32'h0000_0003);
		stOk <= 1'b1;
		waitSig(3, 1'b1, 8);
		@(posedge clk_sys);
		railOk <= 1'b0;
		waitSig(2, 1'b0, 6);
		check(outputOn, 1'b0);
		@(posedge clk_sys);
		regRead(5'h04, 32'h0000_000c);
		test_done();
	end
endmodule : tb
